// ### src/asc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module asc_ctrl (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic [asc_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic [1:0] req_lane_i,
	input wire logic [asc_pkg::DATA_W-1:0] req_wdata_i,
	output logic req_ready_o,
	output logic rd_valid_o,
	output logic [asc_pkg::DATA_W-1:0] rd_data_o,
	output logic [asc_pkg::ADDR_W-1:0] addr_o,
	output logic select_low_active_o,
	output logic select_high_active_o,
	output logic write_n_o,
	output logic out_enable_n_o,
	output logic upper_lane_enable_n_o,
	output logic lower_lane_enable_n_o,
	input wire logic [asc_pkg::DATA_W-1:0] data_i,
	output logic [asc_pkg::DATA_W-1:0] data_o,
	output logic data_oe_n_o
);
	import asc_pkg::*;
	typedef struct packed {
		asc_state_t state;
		logic [CNT_W-1:0] cnt;
		logic [ADDR_W-1:0] addr;
		logic [1:0] lane;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic [DATA_W-1:0] din_s1;
		logic [DATA_W-1:0] din_s2;
	} asc_ctl_t;
	asc_ctl_t st_ff, nxt_st;
	asc_pin_if pin();
	// ==========================================================
	// counter load for a state held c cycles: one less than c
	function automatic logic [CNT_W-1:0] hold_cyc(input int c);
		hold_cyc = CNT_W'(c - 1);
	endfunction
	// ==========================================================
	// sequencer: one access per request, idle between accesses
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rvalid = 1'b0;
		nxt_st.din_s1 = data_i; // data pins pass two flops before use
		nxt_st.din_s2 = st_ff.din_s1;
		case (st_ff.state)
			ASC_IDLE: begin
				if (req_i && req_lane_i != 2'h0) begin
					nxt_st.addr = req_addr_i;
					nxt_st.lane = req_lane_i;
					nxt_st.wdata = req_write_i ? req_wdata_i : st_ff.wdata;
					nxt_st.state = req_write_i ? ASC_TURN : ASC_READ;
					nxt_st.cnt = req_write_i ? hold_cyc(TURN_CYC) : hold_cyc(RD_CYC + 3);
				end
			end
			ASC_READ: begin
				// three extra cycles: pin register, then two synchroniser flops
				if (st_ff.cnt == '0) begin
					nxt_st.rdata = st_ff.din_s2;
					nxt_st.rvalid = 1'b1;
					nxt_st.state = ASC_REL;
				end else begin
					nxt_st.cnt = st_ff.cnt - 1'b1;
				end
			end
			ASC_TURN: begin
				// selects go on from the first turn cycle, strobe low and bus driven from the last turn cycle, output enable off
				if (st_ff.cnt == '0) begin
					nxt_st.state = ASC_WRITE;
					nxt_st.cnt = hold_cyc(WR_CYC);
				end else begin
					nxt_st.cnt = st_ff.cnt - 1'b1;
				end
			end
			ASC_WRITE: begin
				if (st_ff.cnt == '0) begin
					nxt_st.state = ASC_REL;
				end else begin
					nxt_st.cnt = st_ff.cnt - 1'b1;
				end
			end
			ASC_REL: begin
				nxt_st.state = ASC_IDLE;
			end
			default: begin
				nxt_st.state = ASC_IDLE;
			end
		endcase
	end
	// ==========================================================
	// state register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_ff <= '{ASC_IDLE, '0, '0, 2'h0, '0, '0, 1'b0, '0, '0};
		end else begin
			st_ff <= nxt_st;
		end
	end
	// ==========================================================
	// pin intents: strobe rises one cycle before selects drop
	assign pin.sel = st_ff.state inside {ASC_READ, ASC_TURN, ASC_WRITE};
	assign pin.wr = (st_ff.state == ASC_TURN) && (st_ff.cnt == '0) ||
		(st_ff.state == ASC_WRITE) && (st_ff.cnt != '0);
	assign pin.oe = (st_ff.state == ASC_READ);
	assign pin.lane = pin.sel ? st_ff.lane : 2'h0;
	assign pin.drive = (st_ff.state == ASC_TURN) && (st_ff.cnt == '0) ||
		(st_ff.state == ASC_WRITE);
	asc_pin_drv u_drv (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.pin(pin),
		.select_low_active_o(select_low_active_o),
		.select_high_active_o(select_high_active_o),
		.write_n_o(write_n_o),
		.out_enable_n_o(out_enable_n_o),
		.upper_lane_enable_n_o(upper_lane_enable_n_o),
		.lower_lane_enable_n_o(lower_lane_enable_n_o),
		.data_oe_n_o(data_oe_n_o)
	);
	assign addr_o = st_ff.addr;
	assign data_o = st_ff.wdata; // held past strobe rise
	assign req_ready_o = (st_ff.state == ASC_IDLE);
	assign rd_valid_o = st_ff.rvalid;
	assign rd_data_o = st_ff.rdata;
	// ==========================================================
	// checks
	sequence s_wr_end;
		$rose(write_n_o) ##1 select_low_active_o;
	endsequence
	property p_we_high_read;
		@(posedge clk_i) disable iff (srst_i) !out_enable_n_o |-> write_n_o;
	endproperty
	a_we_high_read: assert property (p_we_high_read) else $error("strobe low in read");
	property p_no_drive_oe;
		@(posedge clk_i) disable iff (srst_i) !data_oe_n_o |-> out_enable_n_o;
	endproperty
	a_no_drive_oe: assert property (p_no_drive_oe) else $error("bus contention");
	property p_sel_pair;
		@(posedge clk_i) disable iff (srst_i) select_low_active_o == !select_high_active_o;
	endproperty
	a_sel_pair: assert property (p_sel_pair) else $error("selects disagree");
	property p_release;
		@(posedge clk_i) disable iff (srst_i) $rose(write_n_o) && !select_low_active_o
			|-> s_wr_end;
	endproperty
	a_release: assert property (p_release) else $error("no release after write");
	property p_addr_stable;
		@(posedge clk_i) disable iff (srst_i) !select_low_active_o && $past(!select_low_active_o)
			|-> $stable(addr_o);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved");
	property p_data_hold;
		@(posedge clk_i) disable iff (srst_i) $rose(write_n_o) && !$past(srst_i)
			|-> !data_oe_n_o && $stable(data_o);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data hold lost");
	property p_wr_sel;
		@(posedge clk_i) disable iff (srst_i) !write_n_o |-> !select_low_active_o &&
			!(upper_lane_enable_n_o && lower_lane_enable_n_o);
	endproperty
	a_wr_sel: assert property (p_wr_sel) else $error("strobe outside window");
	property p_rd_len;
		@(posedge clk_i) disable iff (srst_i) $fell(out_enable_n_o)
			|-> !out_enable_n_o[*4] ##1 out_enable_n_o;
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("read too short");
	// ==========================================================
	// handover, bus turnaround and strobe shape
	sequence s_wr_pulse;
		!write_n_o && !data_oe_n_o ##1 write_n_o && !data_oe_n_o && $stable(data_o);
	endsequence
	property p_wr_pulse;
		@(posedge clk_i) disable iff (srst_i) $fell(write_n_o) |-> s_wr_pulse;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write data not held over strobe");
	property p_drive_after_oe;
		@(posedge clk_i) disable iff (srst_i) $fell(data_oe_n_o) |-> $past(out_enable_n_o);
	endproperty
	a_drive_after_oe: assert property (p_drive_after_oe) else $error("drive while memory on");
	property p_addr_setup;
		@(posedge clk_i) disable iff (srst_i) $fell(select_low_active_o) |-> $stable(addr_o);
	endproperty
	a_addr_setup: assert property (p_addr_setup) else $error("address late");
	property p_lane_sel;
		@(posedge clk_i) disable iff (srst_i)
			!select_low_active_o == !(upper_lane_enable_n_o && lower_lane_enable_n_o);
	endproperty
	a_lane_sel: assert property (p_lane_sel) else $error("lanes apart from select");
	property p_idle_release;
		@(posedge clk_i) disable iff (srst_i) req_ready_o |->
			select_low_active_o && write_n_o && out_enable_n_o && data_oe_n_o;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("pins held in idle");
	property p_rd_pulse;
		@(posedge clk_i) disable iff (srst_i) rd_valid_o |=> !rd_valid_o && req_ready_o;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read answer not one cycle");
endmodule
`default_nettype wire

// ### src/asc_pkg.sv
package asc_pkg;
	// ==========================================================
	// memory geometry
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	// ==========================================================
	// timing in ns for the slower speed grade, and clock period
	localparam int CLK_NS = 100;
	localparam int T_RC_NS = 70;
	localparam int T_PWE_NS = 45;
	localparam int T_SD_NS = 30;
	localparam int T_HZWE_NS = 25;
	localparam int T_HZOE_NS = 25;
	// least times round up, at least one cycle
	localparam int RD_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
		(T_RC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WR_CYC = (T_PWE_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
		(T_PWE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TURN_CYC = (T_HZOE_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
		(T_HZOE_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 4;
	// ==========================================================
	// sequencer states, one-hot
	typedef enum logic [4:0] {
		ASC_IDLE = 5'h01,
		ASC_READ = 5'h02,
		ASC_TURN = 5'h04,
		ASC_WRITE = 5'h08,
		ASC_REL = 5'h10
	} asc_state_t;
endpackage

// ### src/asc_pin_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// pin-facing controls handed from sequencer to the pin driver
interface asc_pin_if;
	logic sel;
	logic wr;
	logic oe;
	logic [1:0] lane;
	logic drive;
	modport seq (output sel, output wr, output oe, output lane, output drive);
	modport drv (input sel, input wr, input oe, input lane, input drive);
endinterface
`default_nettype wire

// ### src/asc_pin_drv.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// registers the memory control pins; all pins glitch-free from flops
module asc_pin_drv (
	input wire logic clk_i,
	input wire logic srst_i,
	asc_pin_if.drv pin,
	output logic select_low_active_o,
	output logic select_high_active_o,
	output logic write_n_o,
	output logic out_enable_n_o,
	output logic upper_lane_enable_n_o,
	output logic lower_lane_enable_n_o,
	output logic data_oe_n_o
);
	typedef struct packed {
		logic cs_n;
		logic cs;
		logic we_n;
		logic oe_n;
		logic ub_n;
		logic lb_n;
		logic doe_n;
	} asc_drv_t;
	asc_drv_t st_ff, nxt_st;
	// ==========================================================
	// next pin levels
	always_comb begin
		nxt_st.cs_n = ~pin.sel;
		nxt_st.cs = pin.sel;
		nxt_st.we_n = ~pin.wr;
		nxt_st.oe_n = ~pin.oe;
		nxt_st.ub_n = ~pin.lane[1];
		nxt_st.lb_n = ~pin.lane[0];
		nxt_st.doe_n = ~pin.drive;
	end
	// ==========================================================
	// pin register, idle = deselected and released
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_ff <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign select_low_active_o = st_ff.cs_n;
	assign select_high_active_o = st_ff.cs;
	assign write_n_o = st_ff.we_n;
	assign out_enable_n_o = st_ff.oe_n;
	assign upper_lane_enable_n_o = st_ff.ub_n;
	assign lower_lane_enable_n_o = st_ff.lb_n;
	assign data_oe_n_o = st_ff.doe_n;
endmodule
`default_nettype wire

// ### tb/asc_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// word memory on the far side of the pins, clockless
module asc_mem_model (
	input wire logic [19:0] addr_i,
	input wire logic sel_n_i,
	input wire logic sel_i,
	input wire logic wr_n_i,
	input wire logic oe_n_i,
	input wire logic [1:0] lane_n_i,
	input wire logic [15:0] ctl_dq_i,
	input wire logic ctl_oe_n_i,
	output logic [15:0] bus_o,
	output logic clash_o
);
	logic [15:0] mem [0:(1<<20)-1];
	logic [15:0] last, rword, wd;
	logic [19:0] wa;
	logic [1:0] wl, rd_en;
	logic selected, win;
	// select decode, both lanes high also deselects
	assign selected = !sel_n_i && sel_i && (lane_n_i != 2'h3);
	assign win = selected && !wr_n_i;
	// lanes driven only in a read with oe low
	assign rd_en = (selected && wr_n_i && !oe_n_i) ? ~lane_n_i : 2'h0;
	assign clash_o = (rd_en != 2'h0) && !ctl_oe_n_i;
	// unwritten words read as unknown; a store shows at once
	assign rword = mem[addr_i];
	// track the window; the last values inside it count
	always @* begin
		if (win) begin
			wa = addr_i;
			wl = lane_n_i;
			wd = bus_o;
		end
	end
	// store per lane when any control closes the window
	always @(negedge win) begin
		if (!wl[0]) mem[wa][7:0] = wd[7:0];
		if (!wl[1]) mem[wa][15:8] = wd[15:8];
	end
	// resolve each lane; a floating lane shows the inverse of its last value
	always @* begin
		for (int i = 0; i < 2; i++) begin
			if (!ctl_oe_n_i) last[i*8 +: 8] = ctl_dq_i[i*8 +: 8];
			else if (rd_en[i]) last[i*8 +: 8] = rword[i*8 +: 8];
			bus_o[i*8 +: 8] = (!ctl_oe_n_i || rd_en[i]) ? last[i*8 +: 8] : ~last[i*8 +: 8];
		end
	end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import asc_pkg::*;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic req_i = 1'b0;
	logic req_write_i = 1'b0;
	logic [ADDR_W-1:0] req_addr_i = 20'h00000;
	logic [1:0] req_lane_i = 2'h0;
	logic [DATA_W-1:0] req_wdata_i = 16'h0000;
	logic req_ready_o, rd_valid_o, sel_n, sel, wr_n, oe_n, ue_n, le_n, doe_n, clash;
	logic [DATA_W-1:0] rd_data_o, data_i, data_o, rd;
	logic [ADDR_W-1:0] addr_o, pa;
	logic ps = 1'b0;
	int errors = 0;
	int tests_run = 0;
	always #50 clk_i = ~clk_i;
	asc_ctrl DUT (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i), .req_write_i(req_write_i),
		.req_addr_i(req_addr_i), .req_lane_i(req_lane_i), .req_wdata_i(req_wdata_i),
		.req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
		.addr_o(addr_o), .select_low_active_o(sel_n), .select_high_active_o(sel),
		.write_n_o(wr_n), .out_enable_n_o(oe_n), .upper_lane_enable_n_o(ue_n),
		.lower_lane_enable_n_o(le_n), .data_i(data_i), .data_o(data_o), .data_oe_n_o(doe_n));
	asc_mem_model mem (.addr_i(addr_o), .sel_n_i(sel_n), .sel_i(sel), .wr_n_i(wr_n),
		.oe_n_i(oe_n), .lane_n_i({ue_n, le_n}), .ctl_dq_i(data_o), .ctl_oe_n_i(doe_n),
		.bus_o(data_i), .clash_o(clash));
	// ==========================================================
	// helpers
	task automatic chk(input logic c, input string m);
		tests_run++;
		if (c !== 1'b1) begin
			errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	// one access, from the edge of take until ready again
	task acc(input logic w, input logic [19:0] a, input logic [1:0] ln, input logic [15:0] wd);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		req_i = 1'b1;
		req_write_i = w;
		req_addr_i = a;
		req_lane_i = ln;
		req_wdata_i = wd;
		while (req_ready_o !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			#1 n++;
		end
		@(posedge clk_i);
		#1 req_i = 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			#1 n++;
			if (!w && rd_valid_o === 1'b1) begin
				rd = rd_data_o;
				got = 1'b1;
			end
		end while (req_ready_o !== 1'b1 && n < 20);
		chk(n < 20, "access hung");
		chk(w || got, "no read answer");
		chk(sel_n === 1'b1 && sel === 1'b0 && wr_n === 1'b1 && doe_n === 1'b1, "not released");
	endtask
	// pin watch on the falling edge, where pins are settled
	always @(negedge clk_i) begin
		if (!srst_i) begin
			if (sel_n === 1'b0 && oe_n === 1'b0) chk(wr_n === 1'b1, "strobe low in read");
			chk(clash === 1'b0, "bus contention");
			chk(sel_n === ~sel, "selects disagree");
			if (ps && sel_n === 1'b0) chk(addr_o === pa, "address moved while selected");
			pa = addr_o;
			ps = (sel_n === 1'b0);
		end
	end
	// ==========================================================
	// scenarios
	task t_full;
		acc(1'b1, 20'hFFFFF, 2'h3, 16'hA55A);
		acc(1'b0, 20'hFFFFF, 2'h3, 16'h0000);
		chk(rd === 16'hA55A, "full word");
		$display("full word test done");
	endtask
	task t_reset;
		req_write_i = 1'b1;
		req_addr_i = 20'h00002;
		req_lane_i = 2'h3;
		req_wdata_i = 16'h5AA5;
		req_i = 1'b1;
		@(posedge clk_i);
		#1 req_i = 1'b0;
		@(posedge clk_i);
		#1 chk(wr_n === 1'b0 && doe_n === 1'b0 && sel_n === 1'b0, "write not started");
		srst_i = 1'b1;
		@(posedge clk_i);
		#1 chk(sel_n === 1'b1 && sel === 1'b0 && wr_n === 1'b1, "reset mid write");
		chk(doe_n === 1'b1 && req_ready_o === 1'b1, "bus kept after reset");
		srst_i = 1'b0;
		acc(1'b0, 20'hFFFFF, 2'h3, 16'h0000);
		chk(rd === 16'hA55A, "read after reset");
		$display("mid reset test done");
	endtask
	task t_lanes;
		acc(1'b1, 20'h00001, 2'h3, 16'h1234);
		acc(1'b1, 20'h00001, 2'h1, 16'hFFCD);
		acc(1'b0, 20'h00001, 2'h3, 16'h0000);
		chk(rd === 16'h12CD, "low lane write");
		acc(1'b0, 20'h00001, 2'h1, 16'h0000);
		chk(rd[7:0] === 8'hCD, "low lane read");
		acc(1'b1, 20'h00001, 2'h2, 16'hEFFF);
		acc(1'b0, 20'h00001, 2'h2, 16'h0000);
		chk(rd[15:8] === 8'hEF, "high lane read");
		acc(1'b0, 20'h00001, 2'h3, 16'h0000);
		chk(rd === 16'hEFCD, "high lane write");
		$display("lane test done");
	endtask
	task t_zero;
		req_i = 1'b1;
		req_lane_i = 2'h0;
		repeat (4) begin
			@(posedge clk_i);
			#1 chk(req_ready_o === 1'b1 && sel_n === 1'b1 && le_n === 1'b1, "zero lanes taken");
		end
		req_i = 1'b0;
		$display("zero lane test done");
	endtask
	task complete_run;
		$display("tests_run %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (6) @(posedge clk_i);
		#1 srst_i = 1'b0;
		chk(sel_n === 1'b1 && sel === 1'b0 && doe_n === 1'b1 && req_ready_o === 1'b1, "reset");
		t_full();
		t_reset();
		t_lanes();
		t_zero();
		complete_run();
	end
	initial begin
		#200000;
		errors++;
		complete_run();
	end
endmodule
`default_nettype wire
